/* File: rtl/cms_regs.svh */
`ifndef CMS_REGS_SVH
`define CMS_REGS_SVH
// Register byte addresses
`define CMS_A_CTRL    8'h00
`define CMS_A_ACT     8'h04
`define CMS_A_FACTOR  8'h08
`define CMS_A_TMO     8'h0c
`define CMS_A_STATUS  8'h10
`define CMS_A_MEAS    8'h14
// Control fields
`define CMS_CTRL_ONEDIR 0
`define CMS_CTRL_EN     1
// Reset values
`define CMS_ACT_RST   5'h04
`define CMS_FAC_RST   5'h02
`define CMS_TMO_RST   16'h0258
// Limits of the selectable settings
`define CMS_ACT_MIN   5'h01
`define CMS_ACT_MAX   5'h10
`define CMS_FAC_MIN   5'h02
`define CMS_FAC_MAX   5'h10
// Timing: clock rate, tick period and times in ms
`define CMS_CLK_MHZ   200
`define CMS_TICK_US   1000
`define CMS_MS_PER_S  32'h0000_03e8
`define CMS_DROP_MS   5'h1e
`define CMS_BLINK_MS  9'h1f4
`endif

/* File: rtl/cms_pkg.sv */
package cms_pkg;
  // Sequencer states
  typedef enum logic [2:0] {
    CMS_IDLE  = 3'b000,
    CMS_FIRST = 3'b001,
    CMS_MUTE  = 3'b010,
    CMS_DROP  = 3'b011,
    CMS_REARM = 3'b100
  } cms_state_e;
  // Software settings
  typedef struct packed {
    logic        one_dir;
    logic        enable;
    logic [4:0]  act_s;
    logic [4:0]  factor;
    logic [15:0] timeout_s;
  } cms_cfg_s;
endpackage

/* File: rtl/cms_muting.sv */
`timescale 1ns/100ps
`include "cms_regs.svh"
module cms_muting
  import cms_pkg::*;
#(
  parameter int TICK_CYCLES = `CMS_CLK_MHZ * `CMS_TICK_US
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Sensors and scanner
  input  wire logic        mute_a_pin,
  input  wire logic        mute_b_pin,
  input  wire logic        object_detected,
  // Outputs
  output logic [1:0]       safety_switch_output_pair,
  output logic             muting_lamp,
  output logic             muting_active,
  output logic             timeout_fault
);

  // Sensor synchronisers: three stages, accepted when stages two and three agree
  logic [1:0] pin;
  logic [1:0] s1, s2, s3, filt;
  logic [1:0] next_filt;
  assign pin = {mute_b_pin, mute_a_pin};
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_sync
      always_comb begin
        next_filt[g] = (s2[g] == s3[g]) ? s3[g] : filt[g];
      end
    end
  endgenerate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1   <= 2'h0;
      s2   <= 2'h0;
      s3   <= 2'h0;
      filt <= 2'h0;
    end else begin
      s1   <= pin;
      s2   <= s1;
      s3   <= s2;
      filt <= next_filt;
    end
  end

  logic any_in, both_in;
  assign any_in  = |filt;
  assign both_in = &filt;

  // Millisecond timebase keeps the long counters narrow
  logic [17:0] pre, next_pre;
  logic        tick, next_tick;
  always_comb begin
    next_tick = (pre == 18'(TICK_CYCLES - 1));
    next_pre  = next_tick ? 18'h0 : pre + 18'h1;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre  <= 18'h0;
      tick <= 1'b0;
    end else begin
      pre  <= next_pre;
      tick <= next_tick;
    end
  end

  // APB register file, one wait state so read data comes from a flop
  cms_cfg_s   cfg, next_cfg;
  cms_state_e state, next_state;
  logic [14:0] act_ms, next_act;
  logic [31:0] next_rdata;
  logic        next_ready, next_err, acc, wr;
  logic [4:0]  wv;
  assign acc = psel && penable && !pready;
  assign wr  = acc && pwrite;
  assign wv  = pwdata[4:0];
  always_comb begin
    next_cfg   = cfg;
    next_rdata = 32'h0;
    next_err   = 1'b0;
    next_ready = acc;
    case (paddr)
      `CMS_A_CTRL: begin
        if (wr) begin
          next_cfg.one_dir = pwdata[`CMS_CTRL_ONEDIR];
          next_cfg.enable  = pwdata[`CMS_CTRL_EN];
        end
        next_rdata[`CMS_CTRL_ONEDIR] = cfg.one_dir;
        next_rdata[`CMS_CTRL_EN]     = cfg.enable;
      end
      `CMS_A_ACT: begin
        // Out of range values are clamped into the legal span
        if (wr) begin
          next_cfg.act_s = (wv < `CMS_ACT_MIN) ? `CMS_ACT_MIN :
                           (wv > `CMS_ACT_MAX) ? `CMS_ACT_MAX : wv;
        end
        next_rdata[4:0] = cfg.act_s;
      end
      `CMS_A_FACTOR: begin
        if (wr) begin
          next_cfg.factor = (wv < `CMS_FAC_MIN) ? `CMS_FAC_MIN :
                            (wv > `CMS_FAC_MAX) ? `CMS_FAC_MAX : wv;
        end
        next_rdata[4:0] = cfg.factor;
      end
      `CMS_A_TMO: begin
        if (wr) begin
          next_cfg.timeout_s = pwdata[15:0];
        end
        next_rdata[15:0] = cfg.timeout_s;
      end
      `CMS_A_STATUS: begin
        next_rdata[2:0] = state;
        next_rdata[3]   = muting_active;
        next_rdata[4]   = timeout_fault;
        next_rdata[6:5] = filt;
        next_rdata[8:7] = safety_switch_output_pair;
      end
      `CMS_A_MEAS: next_rdata[14:0] = act_ms;
      default: next_err = acc;
    endcase
    if (!acc || pwrite) begin
      next_rdata = 32'h0;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg     <= '{one_dir: 1'b0, enable: 1'b1, act_s: `CMS_ACT_RST,
                   factor: `CMS_FAC_RST, timeout_s: `CMS_TMO_RST};
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      cfg     <= next_cfg;
      prdata  <= next_rdata;
      pready  <= next_ready;
      pslverr <= next_err;
    end
  end

  // Limits in ms derived from the live settings
  logic [31:0] act_lim, tmo_lim, fac_lim;
  assign act_lim = 32'(cfg.act_s) * `CMS_MS_PER_S;
  assign tmo_lim = 32'(cfg.timeout_s) * `CMS_MS_PER_S;
  assign fac_lim = 32'(act_ms) * 32'(cfg.factor);

  // Muting sequencer; a single state register means one area at a time
  logic [31:0] mute_ms, next_mute;
  logic [4:0]  drop_ms, next_drop;
  logic        fault, next_fault;
  always_comb begin
    next_state = state;
    next_act   = act_ms;
    next_mute  = mute_ms;
    next_drop  = drop_ms;
    next_fault = fault;
    case (state)
      CMS_IDLE: begin
        if (any_in) begin
          next_act = 15'h0;
          if (!cfg.enable || object_detected) begin
            next_state = CMS_REARM;
          end else if (both_in) begin
            next_mute  = 32'h0;
            next_state = CMS_MUTE;
          end else begin
            next_state = CMS_FIRST;
          end
        end
      end
      CMS_FIRST: begin
        if (tick) begin
          next_act = act_ms + 15'h1;
        end
        if (!any_in) begin
          next_state = CMS_IDLE;
        end else if (object_detected) begin
          next_state = CMS_REARM;
        end else if (32'(act_ms) > act_lim) begin
          next_state = CMS_REARM;
        end else if (both_in) begin
          next_mute  = 32'h0;
          next_state = CMS_MUTE;
        end
      end
      CMS_MUTE: begin
        if (tick) begin
          next_mute = mute_ms + 32'h1;
        end
        if (mute_ms >= tmo_lim) begin
          next_fault = 1'b1;
          next_state = CMS_REARM;
        end else if (cfg.one_dir && mute_ms >= fac_lim) begin
          next_state = CMS_REARM;
        end else if (!cfg.one_dir && !both_in) begin
          next_drop  = 5'h0;
          next_state = CMS_DROP;
        end
      end
      CMS_DROP: begin
        // Timeout is not checked here: the inputs are already leaving
        if (tick) begin
          next_drop = drop_ms + 5'h1;
        end
        if (drop_ms >= `CMS_DROP_MS) begin
          next_state = CMS_REARM;
        end
      end
      CMS_REARM: begin
        if (!any_in) begin
          next_fault = 1'b0;
          next_state = CMS_IDLE;
        end
      end
      default: next_state = CMS_IDLE;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state   <= CMS_IDLE;
      act_ms  <= 15'h0;
      mute_ms <= 32'h0;
      drop_ms <= 5'h0;
      fault   <= 1'b0;
    end else begin
      state   <= next_state;
      act_ms  <= next_act;
      mute_ms <= next_mute;
      drop_ms <= next_drop;
      fault   <= next_fault;
    end
  end

  // Outputs follow the next state so they line up with it
  logic       next_muting, next_lamp, blink, next_blink;
  logic [8:0] blink_ms, next_blink_ms;
  logic [1:0] next_pair;
  always_comb begin
    next_muting   = (next_state == CMS_MUTE) || (next_state == CMS_DROP);
    next_blink_ms = blink_ms;
    next_blink    = blink;
    if (!next_muting) begin
      next_blink_ms = 9'h0;
      next_blink    = 1'b1;
    end else if (tick) begin
      if (blink_ms >= `CMS_BLINK_MS - 9'h1) begin
        next_blink_ms = 9'h0;
        next_blink    = !blink;
      end else begin
        next_blink_ms = blink_ms + 9'h1;
      end
    end
    next_lamp = next_muting && next_blink;
    // Muting overrides detection; a timeout fault always drops the pair
    next_pair = {2{(next_muting || !object_detected) && !next_fault}};
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blink_ms                  <= 9'h0;
      blink                     <= 1'b1;
      muting_active             <= 1'b0;
      muting_lamp               <= 1'b0;
      timeout_fault             <= 1'b0;
      safety_switch_output_pair <= 2'h0;
    end else begin
      blink_ms                  <= next_blink_ms;
      blink                     <= next_blink;
      muting_active             <= next_muting;
      muting_lamp               <= next_lamp;
      timeout_fault             <= next_fault;
      safety_switch_output_pair <= next_pair;
    end
  end

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_enter;
    (state == CMS_FIRST) ##1 (state == CMS_MUTE);
  endsequence
  sequence s_end_one;
    (state == CMS_MUTE) && cfg.one_dir && (mute_ms >= fac_lim) && (mute_ms < tmo_lim);
  endsequence

  a_enter_both: assert property (s_enter |-> $past(both_in))
    else $error("muting entered without both inputs");
  a_act_window: assert property (s_enter |-> 32'($past(act_ms)) <= $past(act_lim))
    else $error("muting entered after activation window");
  a_timeout_cut: assert property ((state == CMS_MUTE) && (mute_ms >= tmo_lim)
                                  |=> (state == CMS_REARM) && timeout_fault
                                  && (safety_switch_output_pair == 2'h0))
    else $error("timeout did not cancel muting");
  a_drop_end: assert property ((state == CMS_DROP) && (drop_ms >= `CMS_DROP_MS)
                               |=> state == CMS_REARM)
    else $error("fall delay did not end muting");
  a_factor_end: assert property (s_end_one |=> (state == CMS_REARM) && !fault)
    else $error("factor time did not end muting");
  a_single_area: assert property ((state == CMS_MUTE) |=> state != CMS_FIRST)
    else $error("second activation during muting");
  a_obj_block: assert property ((state == CMS_IDLE) && object_detected |=> state != CMS_MUTE)
    else $error("muting entered with object detected");
  a_pair_on: assert property (muting_active |-> safety_switch_output_pair == 2'h3)
    else $error("output pair off during muting");
  a_lamp_off: assert property (!muting_active |-> !muting_lamp)
    else $error("lamp lit outside muting");
  a_tmo_write: assert property (wr && (paddr == `CMS_A_TMO)
                                |=> cfg.timeout_s == 16'($past(pwdata)))
    else $error("timeout setting not stored");
  a_rearm_hold: assert property ((state == CMS_REARM) && any_in |=> state == CMS_REARM)
    else $error("rearm left with an input high");
  // Lamp starts lit so the operator sees muting from its first cycle
  a_lamp_start: assert property ($rose(muting_active) |-> muting_lamp)
    else $error("lamp dark at muting start");
  // A standing timeout fault must keep the machine stopped
  a_fault_pair: assert property (timeout_fault |-> safety_switch_output_pair == 2'h0)
    else $error("output pair on during timeout fault");

endmodule

/* File: sim/cms_sensor_model.sv */
`timescale 1ns/100ps
// Conveyor sensors: both first sensors on input A, both second sensors on input B
module cms_sensor_model (
  // Clock
  input  wire logic pclk,
  // Material position set by the bench
  input  wire logic at_first,
  input  wire logic at_second,
  // Sensor outputs, quiet until material arrives
  output logic      mute_a_pin = 1'b0,
  output logic      mute_b_pin = 1'b0
);
  // Sensors switch just after the edge; real ones are asynchronous anyway
  always @(posedge pclk) begin
    mute_a_pin <= at_first;
    mute_b_pin <= at_second;
  end
endmodule

/* File: sim/conveyor_muting_sequencer_bench.sv */
`timescale 1ns/100ps
`include "cms_regs.svh"
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin errors++; \
  $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module conveyor_muting_sequencer_bench;
  import cms_pkg::*;
  // Short ms tick keeps second-long windows affordable
  localparam int TK = 10;
  logic        pclk = 1'b0, presetn = 1'b0, obj = 1'b0, at_a = 1'b0, at_b = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, er;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'hdb1f;
  logic [1:0]  safety_switch_output_pair;
  logic        mute_a_pin, mute_b_pin, muting_lamp, muting_active, timeout_fault;
  int          errors = 0, samples_checked = 0;
  int          rv[$] = '{2, 4, 2, 'h258};

  cms_muting #(.TICK_CYCLES(TK)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mute_a_pin(mute_a_pin), .mute_b_pin(mute_b_pin), .object_detected(obj),
    .safety_switch_output_pair(safety_switch_output_pair), .muting_lamp(muting_lamp),
    .muting_active(muting_active), .timeout_fault(timeout_fault));
  cms_sensor_model sens_u (.pclk(pclk), .at_first(at_a), .at_second(at_b),
    .mute_a_pin(mute_a_pin), .mute_b_pin(mute_b_pin));

  // Free-running bus clock
  initial forever #2.5 pclk = ~pclk;

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic summarize();
    if (errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // One APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No fixed latency assumed; only the watchdog ends a hung wait
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd, er);
  endtask

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, rd, er);
    `CHK(nm, e, rd)
  endtask

  // Bounded wait for muting (k=0) or fault (k=1) to reach v
  task automatic wait_out(input int k, input logic v, input int lim, input string nm);
    int n;
    n = 0;
    while ((k ? timeout_fault : muting_active) !== v && n < lim) begin
      @(posedge pclk) #1;
      n++;
    end
    `CHK(nm, v, (k ? timeout_fault : muting_active))
  endtask

  // Material reaches one sensor pair (B when b_first, else A), then the other after gap cycles
  task automatic pass(input logic b_first, input int gap);
    @(posedge pclk);
    if (b_first) at_b <= 1'b1;
    else at_a <= 1'b1;
    idle(gap);
    if (b_first) at_a <= 1'b1;
    else at_b <= 1'b1;
  endtask

  task automatic clear();
    @(posedge pclk);
    at_a <= 1'b0;
    at_b <= 1'b0;
    idle(20);
  endtask

  // Watchdog sized well above the expected 22k cycles
  initial begin
    idle(60000);
    errors++;
    summarize();
  end

  initial begin
    idle(10);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++) rdchk("reset value", 8'(i * 4), rv[i]);
    apb(1'b0, 8'h18, 32'h0, rd, er);
    `CHK("unmapped err", 1'b1, er)
    wr(`CMS_A_ACT, 32'h0);
    rdchk("act clamp", `CMS_A_ACT, 32'h1);
    wr(`CMS_A_FACTOR, 32'h1f);
    rdchk("factor clamp", `CMS_A_FACTOR, 32'h10);
    wr(`CMS_A_FACTOR, 32'h2);
    wr(`CMS_A_TMO, 32'h1);
    // Two-direction passes, random order and gap
    for (int i = 0; i < 3; i++) begin
      seed = lfsr_next(seed);
      pass(seed[0], 1 + int'(seed[8:1]));
      wait_out(0, 1'b1, 20, "mute on");
      `CHK("lamp on", 1'b1, muting_lamp)
      `CHK("pair on", 2'b11, safety_switch_output_pair)
      // An object in the zone must not drop the pair while muting holds
      @(posedge pclk);
      obj <= 1'b1;
      idle(2);
      `CHK("pair muted", 2'b11, safety_switch_output_pair)
      obj <= 1'b0;
      at_b <= 1'b0;
      idle(25 * TK);
      `CHK("fall delay", 1'b1, muting_active)
      wait_out(0, 1'b0, 10 * TK, "mute end");
      `CHK("lamp off", 1'b0, muting_lamp)
      at_b <= 1'b1;
      idle(20);
      `CHK("no rearm", 1'b0, muting_active)
      clear();
    end
    // Object in the zone blocks entry
    obj <= 1'b1;
    pass(1'b0, 5);
    idle(20);
    `CHK("object blocks", 1'b0, muting_active)
    obj <= 1'b0;
    clear();
    // Gap beyond the 1 s window
    pass(1'b1, 1005 * TK);
    idle(20);
    `CHK("late second", 1'b0, muting_active)
    clear();
    // Inputs held past the 1 s timeout
    pass(1'b0, 3);
    wait_out(0, 1'b1, 20, "mute on");
    idle(550 * TK);
    `CHK("lamp blinks", 1'b0, muting_lamp)
    idle(440 * TK);
    `CHK("no early fault", 1'b0, timeout_fault)
    wait_out(1, 1'b1, 20 * TK, "timeout");
    idle(2);
    `CHK("pair off", 2'b00, safety_switch_output_pair)
    `CHK("mute cut", 1'b0, muting_active)
    rdchk("status fault", `CMS_A_STATUS, 32'h74);
    clear();
    wait_out(1, 1'b0, 10, "fault clear");
    // Disabled sequencer refuses entry
    wr(`CMS_A_CTRL, 32'h0);
    pass(1'b0, 5);
    idle(20);
    `CHK("disabled", 1'b0, muting_active)
    clear();
    // One direction: ends at factor 2 times a 20 ms gap
    wr(`CMS_A_CTRL, 32'h3);
    pass(1'b0, 20 * TK);
    wait_out(0, 1'b1, 20, "mute on");
    idle(30 * TK);
    `CHK("one dir hold", 1'b1, muting_active)
    wait_out(0, 1'b0, 15 * TK, "one dir end");
    rdchk("gap meas", `CMS_A_MEAS, 32'h14);
    clear();
    summarize();
  end
endmodule
